// file: dv/ddc_ctrl_tb.sv
`timescale 1ns/100ps
module ddc_ctrl_tb;
    import ddc_pkg::*;
    localparam logic [127:0] WD = {64'h0123456789abcdef, 64'hfedcba9876543210};
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic req_valid_in = 1'b0;
    ddc_req_s req_in = '0;
    logic req_ready_out;
    ddc_pins_s pins_out;
    logic ck_out;
    logic ck_n_out;
    logic dq_oe_out;
    logic dqs_oe_out;
    logic [63:0] dq_out;
    logic [7:0] dqs_out;
    logic [7:0] dm_out;
    int viol;
    int ref_cnt;
    logic [11:0] mode_base;
    logic [11:0] mode_ext;
    logic [127:0] wdata_seen;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #2 clock_in = ~clock_in;

    ddc_ctrl #(.RAS_MAX_CYC(200), .REFC_CYC(5000)) u_ddc_ctrl (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .req_valid_in(req_valid_in),
        .req_in(req_in),
        .req_ready_out(req_ready_out),
        .pins_out(pins_out),
        .ck_out(ck_out),
        .ck_n_out(ck_n_out),
        .dq_out(dq_out),
        .dq_oe_out(dq_oe_out),
        .dqs_out(dqs_out),
        .dqs_oe_out(dqs_oe_out),
        .dm_out(dm_out)
    );

    ddc_mem_model u_ddc_mem_model (
        .ck_in(ck_out),
        .pins_in(pins_out),
        .dq_in(dq_out),
        .dq_oe_in(dq_oe_out),
        .dqs_in(dqs_out),
        .dqs_oe_in(dqs_oe_out),
        .viol_out(viol),
        .ref_cnt_out(ref_cnt),
        .mode_base_out(mode_base),
        .mode_ext_out(mode_ext),
        .wdata_out(wdata_seen)
    );

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [127:0] got, input logic [127:0] exp,
            input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Called at a falling edge; returns at the falling edge after the command
    task automatic issue(input ddc_op_e op, input logic [1:0] bank,
            input logic [11:0] row, input logic ap, input logic [3:0] cmd);
        int n;
        n = 0;
        req_in = '{op: op, bank: bank, row: row, col: 10'h010,
            auto_pre: ap, wdata: WD};
        req_valid_in = 1'b1;
        #1;
        while (req_ready_out !== 1'b1 && n < 2000) begin
            @(negedge clock_in);
            #1;
            n++;
        end
        chk(n < 2000, 1'b1, "taken");
        @(negedge clock_in);
        req_valid_in = 1'b0;
        // Command stands for one cycle only, right after the taking edge
        chk(pins_out.cmd, cmd, "command");
        if (cmd == CMD_ACT || cmd == CMD_LMR) begin
            chk({pins_out.ba, pins_out.addr}, {bank, row}, "row");
        end else if (cmd == CMD_RD || cmd == CMD_WR) begin
            chk({pins_out.ba, pins_out.addr[10:0]},
                {bank, ap, 10'h010}, "col");
        end else if (cmd == CMD_PRE) begin
            chk(pins_out.addr[AP_BIT], ap, "all banks");
        end
        @(negedge clock_in);
    endtask : issue

    task automatic t_reset();
        repeat (3) @(negedge clock_in);
        chk({pins_out, ck_out, dq_oe_out, dqs_oe_out},
            {PINS_RST, 3'b000}, "rst");
        repeat (2) @(negedge clock_in);
        nrst_in = 1'b1;
    endtask : t_reset

    task automatic t_rows();
        issue(OP_ACT, 2'h0, 12'h005, 1'b0, CMD_ACT);
        issue(OP_ACT, 2'h1, 12'h006, 1'b0, CMD_ACT);
        issue(OP_WR, 2'h0, 12'h000, 1'b0, CMD_WR);
        @(negedge clock_in);
        chk({dqs_oe_out, dqs_out}, 9'h100, "preamble");
        @(negedge clock_in);
        chk({dm_out, ck_n_out ^ ck_out}, 9'h001, "mask, clock");
        chk({dq_oe_out, dqs_out, dq_out}, {9'h1ff, WD[63:0]}, "beat0");
        @(negedge clock_in);
        chk({dq_oe_out, dqs_out, dq_out}, {9'h100, WD[127:64]}, "beat1");
        @(negedge clock_in);
        chk({dq_oe_out, dqs_oe_out}, 2'b01, "postamble");
        @(negedge clock_in);
        chk(dqs_oe_out, 1'b0, "strobe off");
        chk(wdata_seen, WD, "captured");
        issue(OP_RD, 2'h0, 12'h000, 1'b0, CMD_RD);
        issue(OP_RD, 2'h1, 12'h000, 1'b1, CMD_RD);
        issue(OP_PRE, 2'h0, 12'h000, 1'b0, CMD_PRE);
        issue(OP_ACT, 2'h1, 12'h008, 1'b0, CMD_ACT);
        issue(OP_WR, 2'h1, 12'h000, 1'b1, CMD_WR);
        issue(OP_PRE, 2'h3, 12'h000, 1'b1, CMD_PRE);
    endtask : t_rows

    task automatic t_mode();
        issue(OP_LMR, 2'h0, 12'h031, 1'b0, CMD_LMR);
        issue(OP_LMR, 2'h1, 12'h002, 1'b0, CMD_LMR);
        issue(OP_LMR, 2'h2, 12'h7ff, 1'b0, CMD_NOP);
        issue(OP_EXIT, 2'h0, 12'h000, 1'b0, CMD_NOP);
        chk({mode_base, mode_ext}, {12'h031, 12'h002}, "modes");
    endtask : t_mode

    task automatic t_sref();
        int c0;
        issue(OP_SREF, 2'h0, 12'h000, 1'b0, CMD_REF);
        repeat (50) @(negedge clock_in);
        chk({pins_out.cke, pins_out.cmd}, {1'b0, CMD_NOP}, "asleep");
        issue(OP_EXIT, 2'h0, 12'h000, 1'b0, CMD_NOP);
        chk(pins_out.cke, 1'b1, "awake");
        c0 = cycles;
        issue(OP_ACT, 2'h2, 12'h0a0, 1'b0, CMD_ACT);
        chk(cycles - c0 >= 399, 1'b1, "exit wait");
        issue(OP_RD, 2'h2, 12'h000, 1'b0, CMD_RD);
    endtask : t_sref

    task automatic t_refresh();
        issue(OP_ACT, 2'h3, 12'h0b0, 1'b0, CMD_ACT);
        // Long idle: refresh and forced row close must come unasked
        repeat (16000) @(negedge clock_in);
        chk(ref_cnt >= 3, 1'b1, "refreshes");
        issue(OP_ACT, 2'h3, 12'h0b1, 1'b0, CMD_ACT);
        chk(viol, 0, "device timing");
    endtask : t_refresh

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            $display("ERROR %0t run did not finish", $time);
            print_verdict();
        end
    end

    initial begin
        t_reset();
        t_rows();
        t_mode();
        t_sref();
        t_refresh();
        print_verdict();
    end
endmodule : ddc_ctrl_tb

// file: dv/ddc_mem_model.sv
`timescale 1ns/100ps
module ddc_mem_model (
    input wire logic ck_in,
    input wire ddc_pkg::ddc_pins_s pins_in,
    input wire logic [63:0] dq_in,
    input wire logic dq_oe_in,
    input wire logic [7:0] dqs_in,
    input wire logic dqs_oe_in,
    output int viol_out,
    output int ref_cnt_out,
    output logic [11:0] mode_base_out,
    output logic [11:0] mode_ext_out,
    output logic [127:0] wdata_out
);
    import ddc_pkg::*;
    localparam real TCK = CLK_PS * CK_DIV / 1000.0;
    ddc_pins_s pd;
    real t_act[4] = '{default: -1.0e6};
    real t_any = -1.0e6;
    real t_ref = -1.0e6;
    real t_mrd = -1.0e6;
    real t_wr = -1.0e6;
    real t_exit = -1.0e6;
    real t_ref0 = 0.0;
    real t_oe = 0.0;
    logic [3:0] open_b = 4'h0;
    logic sref = 1'b0;

    // Pins as they stood just before the memory clock edge moved them
    assign #1 pd = pins_in;

    initial begin
        viol_out = 0;
        ref_cnt_out = 0;
    end

    task automatic need(input logic ok, input string what);
        if (ok !== 1'b1) begin
            viol_out++;
            $display("ERROR %0t device timing %s", $time, what);
        end
    endtask : need

    always @(posedge ck_in) begin : decode
        real t;
        logic [1:0] b;
        t = $realtime;
        b = pd.ba;
        if (sref && pd.cke) begin
            sref = 1'b0;
            t_exit = t;
        end
        if (pd.cmd != CMD_NOP) begin
            need(t - t_mrd >= 10.0 && t - t_exit >= 75.0, "gap");
        end
        case (pd.cmd)
            CMD_ACT: begin
                need(!open_b[b] && t - t_act[b] >= 60.0, "rc");
                need(t - t_any >= 10.0 && t - t_ref >= 70.0, "rrd");
                open_b[b] = 1'b1;
                t_act[b] = t;
                t_any = t;
            end
            CMD_RD, CMD_WR: begin
                // Violation is only counted, device carries on regardless
                need(open_b[b] && t - t_act[b] >= 20.0, "rcd");
                if (pd.cmd == CMD_RD) begin
                    need(t - t_wr >= 4.0 * TCK, "wtr");
                    need(t - t_exit >= 200.0 * TCK, "xsrd");
                    need(!pd.addr[AP_BIT] || t - t_act[b] >= 15.0,
                        "rap");
                end else begin
                    t_wr = t;
                end
                if (pd.addr[AP_BIT]) begin
                    open_b[b] = 1'b0;
                end
            end
            CMD_PRE: begin
                for (int i = 0; i < 4; i++) begin
                    if (pd.addr[AP_BIT] || b == 2'(i)) begin
                        need(!open_b[i] || t - t_act[i] >= 40.0, "ras");
                        open_b[i] = 1'b0;
                    end
                end
            end
            CMD_REF: begin
                if (pd.cke) begin
                    need(open_b == 4'h0 && t - t_ref >= 70.0, "rfc");
                    need(t - t_any >= 60.0, "rc ref");
                    need(ref_cnt_out == 0 || t - t_ref <= 140600.0,
                        "refc");
                    if (ref_cnt_out == 0) begin
                        t_ref0 = t;
                    end
                    ref_cnt_out++;
                    // Slack covers the precharge flush ahead of each refresh
                    need(ref_cnt_out < 2 || (t - t_ref0)
                        / (ref_cnt_out - 1) <= 16600.0, "refi");
                    t_ref = t;
                end else begin
                    need(open_b == 4'h0, "sref");
                    sref = 1'b1;
                end
            end
            CMD_LMR: begin
                need(open_b == 4'h0 && !pd.ba[1], "lmr");
                if (pd.ba[0]) begin
                    mode_ext_out = pd.addr;
                end else begin
                    mode_base_out = pd.addr;
                end
                t_mrd = t;
            end
            default: ;
        endcase
        for (int i = 0; i < 4; i++) begin
            need(!open_b[i] || t - t_act[i] <= 70000.0, "ras max");
        end
    end

    always @(posedge dqs_oe_in) t_oe = $realtime;

    always @(posedge dqs_in[0]) begin
        if (dqs_oe_in) begin
            need($realtime - t_wr >= 0.75 * TCK &&
                $realtime - t_wr <= 1.25 * TCK, "dqss");
            need($realtime - t_oe >= 0.25 * TCK, "wpre");
            #1 wdata_out[63:0] = dq_in;
        end
    end

    always @(negedge dqs_in[0]) begin
        if (dqs_oe_in && dq_oe_in) begin
            #1 wdata_out[127:64] = dq_in;
        end
    end
endmodule : ddc_mem_model

// file: logic/ddc_ctrl.sv
`timescale 1ns/100ps
module ddc_ctrl #(
    parameter int unsigned RAS_MAX_CYC = ddc_pkg::cyc_dn(ddc_pkg::TRAS_MAX_NS),
    parameter int unsigned REFC_CYC = ddc_pkg::cyc_dn(ddc_pkg::TREFC_NS)
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic req_valid_in,
    input wire ddc_pkg::ddc_req_s req_in,
    output logic req_ready_out,
    output ddc_pkg::ddc_pins_s pins_out,
    output logic ck_out,
    output logic ck_n_out,
    output logic [63:0] dq_out,
    output logic dq_oe_out,
    output logic [7:0] dqs_out,
    output logic dqs_oe_out,
    output logic [7:0] dm_out
);
    import ddc_pkg::*;

    ddc_state_s s_reg;
    ddc_state_s s_next;

    always_comb begin
        logic all_closed;
        logic all_pre_ok;
        logic all_act_ok;
        logic guard;
        logic ok;
        logic [1:0] b;
        ddc_cnt_t np;
        logic ref_due;
        all_closed = ~|s_reg.open;
        ref_due = 1'b0;
        all_pre_ok = 1'b1;
        all_act_ok = 1'b1;
        guard = 1'b0;
        ok = 1'b0;
        b = req_in.bank;
        np = '0;
        s_next = s_reg;
        req_ready_out = 1'b0;
        // Memory clock is the controller clock divided by two
        s_next.ph = ~s_reg.ph;
        s_next.pins.cmd = CMD_NOP;
        for (int i = 0; i < 4; i++) begin
            if (s_reg.act_cnt[i] != '0) begin
                s_next.act_cnt[i] = s_reg.act_cnt[i] - 6'h01;
            end
            if (s_reg.col_cnt[i] != '0) begin
                s_next.col_cnt[i] = s_reg.col_cnt[i] - 6'h01;
            end
            if (s_reg.pre_cnt[i] != '0) begin
                s_next.pre_cnt[i] = s_reg.pre_cnt[i] - 6'h01;
            end
            if (s_reg.open[i] && s_reg.open_cnt[i] != '0) begin
                s_next.open_cnt[i] = s_reg.open_cnt[i] - 15'h0001;
            end
            if (s_reg.pre_cnt[i] != '0) all_pre_ok = 1'b0;
            if (s_reg.act_cnt[i] != '0) all_act_ok = 1'b0;
            // Close rows well before the longest open time runs out
            if (s_reg.open[i] && s_reg.open_cnt[i] < PRE_GUARD) begin
                guard = 1'b1;
            end
        end
        if (s_reg.rrd != '0) s_next.rrd = s_reg.rrd - 6'h01;
        if (s_reg.mrd != '0) s_next.mrd = s_reg.mrd - 6'h01;
        if (s_reg.rfc != '0) s_next.rfc = s_reg.rfc - 6'h01;
        if (s_reg.wtr != '0) s_next.wtr = s_reg.wtr - 6'h01;
        if (s_reg.xsr != '0) s_next.xsr = s_reg.xsr - 9'h001;
        if (s_reg.st == ST_RUN) begin
            s_next.since_ref = s_reg.since_ref + 16'h0001;
            // Timer restarts at the due point, so the average stays exact
            if (s_reg.ref_tmr == T_REFI - 12'h001) begin
                s_next.ref_tmr = '0;
                s_next.ref_pend = 1'b1;
                ref_due = 1'b1;
            end else begin
                s_next.ref_tmr = s_reg.ref_tmr + 12'h001;
            end
        end
        // Write strobe: two low preamble cycles, one high, one low, then postamble
        if (s_reg.wseq != '0) begin
            s_next.wseq = (s_reg.wseq == 3'h6) ? 3'h0 : s_reg.wseq + 3'h1;
        end
        s_next.dqs_oe = s_next.wseq >= 3'h2;
        s_next.dqs = s_next.wseq == 3'h4;
        s_next.dq_oe = s_next.wseq == 3'h4 || s_next.wseq == 3'h5;
        if (s_next.wseq == 3'h4) s_next.dq = s_reg.wbuf[63:0];
        if (s_next.wseq == 3'h5) s_next.dq = s_reg.wbuf[127:64];

        case (req_in.op)
            OP_ACT: ok = !s_reg.open[b] && s_reg.act_cnt[b] == '0
                && s_reg.rrd == '0 && s_reg.rfc == '0;
            OP_RD: ok = s_reg.open[b] && s_reg.col_cnt[b] == '0
                && s_reg.wtr == '0 && s_reg.wseq == '0;
            OP_WR: ok = s_reg.open[b] && s_reg.col_cnt[b] == '0
                && s_reg.wseq == '0;
            OP_PRE: ok = req_in.auto_pre ? all_pre_ok
                : s_reg.pre_cnt[b] == '0;
            OP_EXIT: ok = 1'b1;
            default: ok = all_closed && all_act_ok && s_reg.rfc == '0
                && s_reg.wseq == '0;
        endcase

        // Commands change while the memory clock is low
        if (s_reg.ph) begin
            case (s_reg.st)
                ST_RUN: begin
                    if (s_reg.mrd != '0) begin
                    end else if (s_reg.ref_pend || guard) begin
                        if (!all_closed) begin
                            if (all_pre_ok) begin
                                s_next.pins.cmd = CMD_PRE;
                                s_next.pins.addr = 12'h000;
                                s_next.pins.addr[AP_BIT] = 1'b1;
                                s_next.open = '0;
                                for (int i = 0; i < 4; i++) begin
                                    s_next.act_cnt[i] =
                                        cmax(s_reg.act_cnt[i], T_RP);
                                end
                            end
                        end else if (s_reg.ref_pend && all_act_ok
                                && s_reg.rfc == '0) begin
                            s_next.pins.cmd = CMD_REF;
                            s_next.rfc = T_RFC;
                            // Set wins: a refresh due this cycle stays owed
                            s_next.ref_pend = ref_due;
                            s_next.since_ref = '0;
                        end
                    end else if (req_valid_in && ok) begin
                        req_ready_out = 1'b1;
                        s_next.pins.ba = b;
                        s_next.pins.addr = {1'b0, req_in.auto_pre, req_in.col};
                        case (req_in.op)
                            OP_ACT: begin
                                s_next.pins.cmd = CMD_ACT;
                                s_next.pins.addr = req_in.row;
                                s_next.open[b] = 1'b1;
                                s_next.open_cnt[b] = 15'(RAS_MAX_CYC);
                                s_next.pre_cnt[b] = T_RAS;
                                s_next.col_cnt[b] = T_COL;
                                s_next.act_cnt[b] = T_RC;
                                s_next.rrd = T_RRD;
                            end
                            OP_RD, OP_WR: begin
                                np = s_reg.pre_cnt[b];
                                if (req_in.op == OP_WR) begin
                                    s_next.pins.cmd = CMD_WR;
                                    s_next.wseq = 3'h1;
                                    s_next.wbuf = req_in.wdata;
                                    s_next.wtr = T_WTR;
                                    np = cmax(np, T_WRP);
                                    s_next.pre_cnt[b] = np;
                                end else begin
                                    s_next.pins.cmd = CMD_RD;
                                end
                                if (req_in.auto_pre) begin
                                    s_next.open[b] = 1'b0;
                                    s_next.act_cnt[b] = cmax(
                                        s_reg.act_cnt[b], np + T_RP + T_BL);
                                end
                            end
                            OP_PRE: begin
                                s_next.pins.cmd = CMD_PRE;
                                for (int i = 0; i < 4; i++) begin
                                    if (req_in.auto_pre
                                            || b == 2'(i)) begin
                                        s_next.open[i] = 1'b0;
                                        s_next.act_cnt[i] =
                                            cmax(s_reg.act_cnt[i], T_RP);
                                    end
                                end
                            end
                            OP_LMR: begin
                                // Reserved targets are taken and dropped
                                if (!b[1]) begin
                                    s_next.pins.cmd = CMD_LMR;
                                    s_next.pins.addr = req_in.row;
                                    s_next.mrd = T_MRD;
                                end
                            end
                            OP_SREF: begin
                                s_next.pins.cmd = CMD_REF;
                                s_next.pins.cke = 1'b0;
                                s_next.st = ST_SREF;
                                s_next.ref_pend = ref_due;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_SREF: begin
                    if (req_valid_in && req_in.op == OP_EXIT) begin
                        req_ready_out = 1'b1;
                        s_next.pins.cke = 1'b1;
                        s_next.st = ST_XSR;
                        s_next.xsr = T_XSR;
                    end
                end
                ST_XSR: begin
                    if (s_reg.xsr == '0) begin
                        s_next.st = ST_RUN;
                        s_next.ref_tmr = '0;
                        s_next.since_ref = '0;
                    end
                end
                default: s_next.st = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= '0;
            s_reg.pins <= PINS_RST;
            s_reg.st <= ST_RUN;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pins_out = s_reg.pins;
    assign ck_out = s_reg.ph;
    assign ck_n_out = ~s_reg.ph;
    assign dq_out = s_reg.dq;
    assign dq_oe_out = s_reg.dq_oe;
    assign dqs_out = {8{s_reg.dqs}};
    assign dqs_oe_out = s_reg.dqs_oe;
    // No byte masking; every written byte is kept
    assign dm_out = 8'h00;

    logic is_act;
    logic is_pre;
    logic is_rd;
    logic is_wr;
    logic is_ref;
    logic is_lmr;
    assign is_act = pins_out.cmd == CMD_ACT;
    assign is_pre = pins_out.cmd == CMD_PRE;
    assign is_rd = pins_out.cmd == CMD_RD;
    assign is_wr = pins_out.cmd == CMD_WR;
    assign is_ref = pins_out.cmd == CMD_REF;
    assign is_lmr = pins_out.cmd == CMD_LMR;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    sequence wr_preamble_s;
        (dqs_oe_out && dqs_out == 8'h00)[*2];
    endsequence
    sequence wr_strobe_s;
        (dqs_oe_out && dqs_out == 8'hff) ##1 (dqs_oe_out && dqs_out == 8'h00);
    endsequence

    wr_strobe_align_a: assert property (
        is_wr |-> ##1 wr_preamble_s ##1 wr_strobe_s)
        else $error("write strobe not one clock after write");
    act_spacing_a: assert property (is_act |=> !is_act [*2])
        else $error("activates too close");
    mode_load_wait_a: assert property (
        is_lmr |=> (pins_out.cmd == CMD_NOP) [*2])
        else $error("command too soon after mode load");
    refresh_gap_a: assert property (
        is_ref && pins_out.cke |=> !(is_act || is_ref) [*8]
        ##1 !(is_act || is_ref) [*8] ##1 !(is_act || is_ref))
        else $error("refresh period violated");
    write_to_read_a: assert property (is_wr |=> !is_rd [*8])
        else $error("read too soon after write");
    refresh_interval_a: assert property (
        s_reg.since_ref < 16'(REFC_CYC))
        else $error("refresh interval exceeded");
    sref_exit_quiet_a: assert property (
        $rose(pins_out.cke) |=> (pins_out.cmd == CMD_NOP) [*8])
        else $error("command during self refresh exit");

    for (genvar g = 0; g < 4; g++) begin : g_bank
        logic hit_act;
        logic hit_pre;
        logic hit_col;
        assign hit_act = is_act && pins_out.ba == 2'(g);
        assign hit_pre = is_pre && (pins_out.addr[AP_BIT]
            || pins_out.ba == 2'(g));
        assign hit_col = (is_rd || is_wr) && pins_out.ba == 2'(g);
        ras_min_a: assert property (
            hit_act |=> !hit_pre [*8] ##1 !hit_pre)
            else $error("row closed too early");
        ras_max_a: assert property (
            s_reg.open[g] |-> s_reg.open_cnt[g] != 15'h0000)
            else $error("row open too long");
        rcd_a: assert property (hit_act |=> !hit_col [*4])
            else $error("column command too soon");
        row_cycle_a: assert property (
            hit_act |=> !(hit_act || is_ref) [*8]
            ##1 !(hit_act || is_ref) [*6])
            else $error("row cycle too short");
    end

endmodule : ddc_ctrl

// file: logic/ddc_pkg.sv
package ddc_pkg;

    // Controller clock period and the divider that makes the memory clock
    localparam int unsigned CLK_PS = 4000;
    localparam int unsigned CK_DIV = 2;

    function automatic int unsigned cyc_up(input int unsigned ns);
        return (ns * 1000 + CLK_PS - 1) / CLK_PS;
    endfunction : cyc_up

    function automatic int unsigned cyc_dn(input int unsigned ns);
        return (ns * 1000 < CLK_PS) ? 1 : ns * 1000 / CLK_PS;
    endfunction : cyc_dn

    typedef logic [5:0] ddc_cnt_t;

    function automatic ddc_cnt_t cmax(input ddc_cnt_t a, input ddc_cnt_t b);
        return (a > b) ? a : b;
    endfunction : cmax

    // Times in ns as printed, memory clock counts in tCK
    localparam int unsigned TRAS_NS = 40;
    localparam int unsigned TRAS_MAX_NS = 70_000;
    localparam int unsigned TRAP_NS = 15;
    localparam int unsigned TRC_NS = 60;
    localparam int unsigned TRFC_NS = 70;
    localparam int unsigned TRCD_NS = 20;
    localparam int unsigned TRP_NS = 20;
    localparam int unsigned TRRD_NS = 10;
    localparam int unsigned TMRD_NS = 10;
    localparam int unsigned TWR_NS = 15;
    localparam int unsigned TXSNR_NS = 75;
    localparam int unsigned TREFI_NS = 15_600;
    localparam int unsigned TREFC_NS = 140_600;
    localparam int unsigned TWTR_TCK = 2;
    localparam int unsigned TXSRD_TCK = 200;
    localparam int unsigned BURST_TCK = 2;

    localparam ddc_cnt_t T_RAS = 6'(cyc_up(TRAS_NS));
    localparam ddc_cnt_t T_RAP = 6'(cyc_up(TRAP_NS));
    localparam ddc_cnt_t T_RCD = 6'(cyc_up(TRCD_NS));
    localparam ddc_cnt_t T_COL = (T_RCD > T_RAP) ? T_RCD : T_RAP;
    localparam ddc_cnt_t T_RC = 6'(cyc_up(TRC_NS));
    localparam ddc_cnt_t T_RFC = 6'(cyc_up(TRFC_NS));
    localparam ddc_cnt_t T_RP = 6'(cyc_up(TRP_NS));
    localparam ddc_cnt_t T_RRD = 6'(cyc_up(TRRD_NS));
    localparam ddc_cnt_t T_MRD = 6'(cyc_up(TMRD_NS));
    localparam ddc_cnt_t T_BL = 6'(BURST_TCK * CK_DIV);
    // Write data ends five cycles after the command shows on the pins
    localparam ddc_cnt_t W_END = 6'h05;
    localparam ddc_cnt_t T_WRP = W_END + 6'(cyc_up(TWR_NS));
    localparam ddc_cnt_t T_WTR = W_END + 6'(TWTR_TCK * CK_DIV);
    localparam int unsigned XSR_RAW = TXSRD_TCK * CK_DIV;
    localparam logic [8:0] T_XSR = 9'((cyc_up(TXSNR_NS) > XSR_RAW) ?
        cyc_up(TXSNR_NS) : XSR_RAW);
    localparam logic [11:0] T_REFI = 12'(cyc_dn(TREFI_NS));
    localparam logic [14:0] PRE_GUARD = 15'h0040;

    // Command codes as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_LMR = 4'h0;
    localparam int unsigned AP_BIT = 10;

    typedef enum logic [2:0] {
        OP_ACT, OP_RD, OP_WR, OP_PRE, OP_LMR, OP_SREF, OP_EXIT
    } ddc_op_e;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001, ST_SREF = 3'b010, ST_XSR = 3'b100
    } ddc_st_e;

    typedef struct packed {
        ddc_op_e op;
        logic [1:0] bank;
        logic [11:0] row;
        logic [9:0] col;
        logic auto_pre;
        logic [127:0] wdata;
    } ddc_req_s;

    typedef struct packed {
        logic cke;
        logic [3:0] cmd;
        logic [1:0] ba;
        logic [11:0] addr;
    } ddc_pins_s;

    localparam ddc_pins_s PINS_RST = '{cke: 1'b1, cmd: CMD_NOP,
        ba: 2'h0, addr: 12'h000};

    typedef struct packed {
        logic ph;
        ddc_st_e st;
        ddc_pins_s pins;
        logic [3:0] open;
        logic [3:0][5:0] act_cnt;
        logic [3:0][5:0] col_cnt;
        logic [3:0][5:0] pre_cnt;
        logic [3:0][14:0] open_cnt;
        ddc_cnt_t rrd;
        ddc_cnt_t mrd;
        ddc_cnt_t rfc;
        ddc_cnt_t wtr;
        logic [8:0] xsr;
        logic [11:0] ref_tmr;
        logic ref_pend;
        logic [2:0] wseq;
        logic [127:0] wbuf;
        logic [63:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_oe;
        logic [15:0] since_ref;
    } ddc_state_s;

endpackage : ddc_pkg
